// >>> disp_port_pkg.sv
// package: constants and types shared by both ends of the display host port
package disp_port_pkg;
  localparam int DATA_W = 8; // data bus width, bit 7 is the msb
  localparam int ADDR_W = 3; // address width
  localparam int NUM_DIGITS = 4; // character locations
  localparam int DIGIT_IDX_W = 2; // index width for digits
  localparam int CLEAR_BIT = 7; // clear bit in the control word
  localparam int CLK_HZ = 40_000_000; // system clock rate
  localparam int QUIET_NS = 1000; // quiet time after a clear write, 1 us
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // least time, so round up
  localparam int QUIET_CYCLES = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_W = 6; // counter width, holds QUIET_CYCLES
  localparam int CLK_DIV = 4; // internal clock divider half period (own choice)
  localparam int CLK_DIV_W = 3;
  localparam int BLINK_W = 24; // blink timer width
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00; // control word after power up
  localparam logic [DATA_W-1:0] DIGIT_RESET = 8'h20; // blank character at power up
  typedef logic [DATA_W-1:0] data_t;
  typedef logic [ADDR_W-1:0] addr_t;
  // host sequencer states, gray on every step except IDLE to WRITE and WRITE to IDLE
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_READ  = 2'b01,
    H_WRITE = 2'b11,
    H_QUIET = 2'b10
  } host_state_e;
  // address decode: top bit low selects the control word
  function automatic logic is_ctrl(input addr_t a);
    return ~a[ADDR_W-1];
  endfunction
endpackage

// >>> disp_port_if.sv
// interface: parallel bus between host and display port
`timescale 1ns/1ps
interface disp_port_if;
  import disp_port_pkg::*;
  logic  select_active_low; // chip select, active low
  logic  select_active_high; // chip select, active high
  addr_t addr; // address, bit 2 is address_top_bit
  logic  rd_n; // read strobe
  logic  wr_n; // write strobe
  data_t data_h2d; // host data out
  logic  data_h_oe; // host drives data
  data_t data_d2h; // device data out
  logic  data_d_oe; // device drives data
  logic  clk_sel; // high: device drives clock pin
  logic  clk_io_out; // device clock pin output
  logic  clk_io_oe; // device clock pin enable
  logic  clk_io_in; // clock pin as seen by device
  logic  blink_rst_n; // blink sync reset, active low
  // resolved data bus level
  data_t data_bus;
  assign data_bus = data_d_oe ? data_d2h : data_h2d;
  modport host (output select_active_low, select_active_high, addr, rd_n, wr_n,
                output data_h2d, data_h_oe, blink_rst_n, clk_sel,
                input data_bus);
  modport device (input select_active_low, select_active_high, addr, rd_n, wr_n,
                  input data_bus, clk_sel, clk_io_in, blink_rst_n,
                  output data_d2h, data_d_oe, clk_io_out, clk_io_oe);
endinterface

// >>> disp_port_device.sv
// display device end: register store, read drive, clock pin and blink sync
//
// Overview of operation
// (R1) host waits 1 us after clear-set write
// (R2) host waits 1 us after clear-release write
// (R3) other accesses may run back to back
// (R4) selected low read returns any register
// (R5) clock select low: clock from pin
// (R6) clock select high: drive clock out
// (R7) blink reset realigns blink timing only
// (R8) selected low write loads addressed location
// (R9) data bus eight bits, bit 7 msb
// (R10) host holds both selects active per access
// (R11) low addresses all map one control word
// (R12) pins output on read, input on write
// (R13) pins released when no selected read
`timescale 1ns/1ps
module disp_port_device
  import disp_port_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  disp_port_if.device      bus,
  output disp_port_pkg::data_t ctrl_word,
  output disp_port_pkg::data_t digit0,
  output disp_port_pkg::data_t digit1,
  output disp_port_pkg::data_t digit2,
  output disp_port_pkg::data_t digit3,
  output logic             disp_clk,
  output logic             blink_phase,
  output logic             clearing
);
  import disp_port_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [6:0] ctl_s1_q; // first stage, read only by second stage
  logic [6:0] ctl_s2_q; // second stage, used by logic
  addr_t      addr_s1_q;
  addr_t      addr_s2_q;
  data_t      data_s1_q;
  data_t      data_s2_q;
  // pins come from outside the clock domain
  always_ff @(posedge clk) begin
    ctl_s1_q  <= {bus.select_active_low, bus.select_active_high, bus.rd_n, bus.wr_n,
                  bus.clk_sel, bus.clk_io_in, bus.blink_rst_n};
    ctl_s2_q  <= ctl_s1_q;
    addr_s1_q <= bus.addr;
    addr_s2_q <= addr_s1_q;
    data_s1_q <= bus.data_bus;
    data_s2_q <= data_s1_q;
  end

  logic sel;      // both selects active
  logic rd_act;   // selected read level
  logic wr_act;   // selected write level
  logic wr_act_q; // previous write level
  logic wr_end;   // write strobe released, data settled
  assign sel    = ~ctl_s2_q[6] & ctl_s2_q[5]; // R10
  // both strobes low is no operation
  assign rd_act = sel & ~ctl_s2_q[4] & ctl_s2_q[3];
  assign wr_act = sel & ctl_s2_q[4] & ~ctl_s2_q[3];
  // commit on release: data is stable the whole strobe
  assign wr_end = wr_act_q & ~wr_act;

  // ----------------------------------------------------------------
  // registers: control word and four digits
  // ----------------------------------------------------------------
  data_t ctrl_q; // one word behind four addresses
  data_t digit_q [NUM_DIGITS]; // character store
  data_t wdata_q; // data captured during the strobe
  addr_t waddr_q; // address captured during the strobe

  // capture data while strobe is held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_act_q <= 1'b0;
      wdata_q  <= CTRL_RESET;
      waddr_q  <= '0;
    end else begin
      wr_act_q <= wr_act;
      if (wr_act) begin
        wdata_q <= data_s2_q;
        waddr_q <= addr_s2_q;
      end
    end
  end

  // control word write, any low address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_end && is_ctrl(waddr_q)) begin
      ctrl_q <= wdata_q; // R11 R8
    end
  end

  // digit writes; clear bit blanks every digit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_DIGITS; i++) begin
        digit_q[i] <= DIGIT_RESET;
      end
    end else if (ctrl_q[CLEAR_BIT]) begin
      // memory clear held while the bit stays set
      for (int i = 0; i < NUM_DIGITS; i++) begin
        digit_q[i] <= DIGIT_RESET;
      end
    end else if (wr_end && !is_ctrl(waddr_q)) begin
      digit_q[waddr_q[DIGIT_IDX_W-1:0]] <= wdata_q; // R8
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  data_t rdata_q; // registered read data
  logic  doe_q;   // registered drive enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= CTRL_RESET;
      doe_q   <= 1'b0;
    end else begin
      doe_q <= rd_act; // R12 R13
      if (is_ctrl(addr_s2_q)) begin
        rdata_q <= ctrl_q; // R4 R11
      end else begin
        rdata_q <= digit_q[addr_s2_q[DIGIT_IDX_W-1:0]]; // R4
      end
    end
  end
  assign bus.data_d2h = rdata_q; // R9
  assign bus.data_d_oe = doe_q; // R12 R13

  // ----------------------------------------------------------------
  // clock pin: master drives divided clock, slave follows pin
  // ----------------------------------------------------------------
  logic [CLK_DIV_W-1:0] div_q; // divider count
  logic                 int_clk_q; // internal oscillator stand-in
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q     <= '0;
      int_clk_q <= 1'b0;
    end else if (div_q == CLK_DIV_W'(CLK_DIV - 1)) begin
      div_q     <= '0;
      int_clk_q <= ~int_clk_q;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign bus.clk_io_out = int_clk_q; // R6
  assign bus.clk_io_oe  = ctl_s2_q[2]; // R6
  // sampled pin is a plain input when not master
  logic op_clk; // operating clock level
  assign op_clk = ctl_s2_q[2] ? int_clk_q : ctl_s2_q[1]; // R5 R6

  // ----------------------------------------------------------------
  // blink timer: reset only realigns it, never touches storage
  // ----------------------------------------------------------------
  logic                op_clk_q; // for edge detect on the operating clock
  logic [BLINK_W-1:0]  blink_q;  // blink counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_clk_q <= 1'b0;
      blink_q  <= '0;
    end else begin
      op_clk_q <= op_clk;
      if (!ctl_s2_q[0]) begin
        blink_q <= '0; // R7
      end else if (op_clk && !op_clk_q) begin
        blink_q <= blink_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs toward display logic, all from flip-flops
  // ----------------------------------------------------------------
  assign ctrl_word   = ctrl_q;
  assign digit0      = digit_q[0];
  assign digit1      = digit_q[1];
  assign digit2      = digit_q[2];
  assign digit3      = digit_q[3];
  assign disp_clk    = op_clk_q;
  assign blink_phase = blink_q[BLINK_W-1];
  assign clearing    = ctrl_q[CLEAR_BIT];
endmodule

// >>> disp_port_host.sv
// host end: turns one-cycle requests into strobed bus cycles
`timescale 1ns/1ps
module disp_port_host
  import disp_port_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  disp_port_if.host           bus,
  input  wire logic           req_valid,
  input  wire logic           req_write,
  input  disp_port_pkg::addr_t req_addr,
  input  disp_port_pkg::data_t req_wdata,
  output logic                req_ready,
  output logic                rsp_valid,
  output disp_port_pkg::data_t rsp_rdata,
  input  wire logic           master_clk,
  input  wire logic           blink_sync_n
);
  import disp_port_pkg::*;

  localparam int STROBE_CYC = 8; // strobe length, covers sync and read latency
  localparam int DRIVE_DLY = 3; // device release latency after a read
  localparam logic [QUIET_W-1:0] QUIET_LAST = QUIET_W'(QUIET_CYCLES - 1);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  host_state_e state_q;
  logic [QUIET_W-1:0] cnt_q; // strobe or quiet counter
  addr_t addr_q;
  data_t wdata_q;
  logic  clear_wr_q; // this write touches the clear bit
  data_t rdata_q;
  logic  rsp_q;
  data_t bus_s1_q; // read data sync stages
  data_t bus_s2_q;

  always_ff @(posedge clk) begin
    bus_s1_q <= bus.data_bus;
    bus_s2_q <= bus_s1_q;
  end

  // one strobe at a time; quiet wait after any control word write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q    <= H_IDLE;
      cnt_q      <= '0;
      addr_q     <= '0;
      wdata_q    <= CTRL_RESET;
      clear_wr_q <= 1'b0;
      rdata_q    <= CTRL_RESET;
      rsp_q      <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      unique case (state_q)
        H_IDLE: begin
          cnt_q <= '0;
          if (req_valid) begin
            addr_q     <= req_addr;
            wdata_q    <= req_wdata;
            clear_wr_q <= req_write & is_ctrl(req_addr);
            state_q    <= req_write ? H_WRITE : H_READ; // R3
          end
        end
        H_READ: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == QUIET_W'(STROBE_CYC - 1)) begin
            rdata_q <= bus_s2_q; // R9
            rsp_q   <= 1'b1;
            state_q <= H_IDLE;
          end
        end
        H_WRITE: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == QUIET_W'(STROBE_CYC - 1)) begin
            cnt_q   <= '0;
            // setting or releasing clear both need the gap
            state_q <= clear_wr_q ? H_QUIET : H_IDLE; // R1 R2 R3
          end
        end
        H_QUIET: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == QUIET_LAST) begin
            state_q <= H_IDLE; // R1 R2
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  logic active; // strobe phase
  assign active = (state_q == H_READ) || (state_q == H_WRITE);
  assign bus.select_active_low  = ~active; // R10
  assign bus.select_active_high = active; // R10
  assign bus.addr      = addr_q;
  assign bus.rd_n      = ~(state_q == H_READ);
  assign bus.wr_n      = ~(state_q == H_WRITE);
  assign bus.data_h2d  = wdata_q;
  // hold off driving until a device still finishing a read has let go
  assign bus.data_h_oe = (state_q == H_WRITE) && (cnt_q >= QUIET_W'(DRIVE_DLY)); // R12 R13
  assign bus.clk_sel   = master_clk;
  assign bus.blink_rst_n = blink_sync_n;

  assign req_ready = (state_q == H_IDLE);
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
endmodule

// >>> disp_port_asserts.sv
// checker: protocol assertions on the bus between host and display ends
`timescale 1ns/1ps
module disp_port_asserts
  import disp_port_pkg::*;
(
  input wire logic           clk,
  input wire logic           rst_n,
  input wire logic           select_active_low,
  input wire logic           select_active_high,
  input disp_port_pkg::addr_t addr,
  input wire logic           rd_n,
  input wire logic           wr_n,
  input wire logic           data_d_oe,
  input wire logic           clk_sel,
  input wire logic           clk_io_oe,
  input wire logic           data_h_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic               sel;     // both selects active
  logic [QUIET_W-1:0] quiet_q; // silent cycles still owed
  logic               wr_q;    // write strobe, one sample back
  logic               top_q;   // address top bit, one sample back
  assign sel = !select_active_low && select_active_high;
  // ----------------------------------
  // quiet gap after any control write
  // ----------------------------------
  // counted from the strobe's release, since the gap is owed after the cycle
  always_ff @(posedge clk) begin
    wr_q  <= rst_n ? wr_n : 1'b1;
    top_q <= addr[ADDR_W-1];
    if (!rst_n) begin
      quiet_q <= '0;
    end else if (wr_n && !wr_q && !top_q) begin
      quiet_q <= QUIET_W'(QUIET_CYCLES);
    end else if (quiet_q != '0) begin
      quiet_q <= quiet_q - 1'b1;
    end
  end
  // ----------------------------------
  // assertions
  // ----------------------------------
  a_quiet_gap: assert property (quiet_q != '0 |-> rd_n && wr_n)
    else $error("strobe inside quiet gap");
  a_strobe_excl: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes together");
  a_read_pulse: assert property ($fell(rd_n) |-> (sel && !rd_n)[*8] ##1 rd_n)
    else $error("read strobe not eight selected cycles");
  a_write_pulse: assert property ($fell(wr_n) |-> (sel && !wr_n)[*8] ##1 wr_n)
    else $error("write strobe not eight selected cycles");
  a_read_drive: assert property ((sel && !rd_n)[*5] |-> data_d_oe)
    else $error("device not driving during read");
  a_bus_release: assert property (rd_n[*5] |-> !data_d_oe)
    else $error("device drives bus without read");
  a_bus_owner: assert property (!(data_h_oe && data_d_oe))
    else $error("host and device drive data together");
  a_clk_master: assert property (clk_sel[*6] |-> clk_io_oe)
    else $error("clock pin not driven as master");
  a_clk_slave: assert property (!clk_sel[*6] |-> !clk_io_oe)
    else $error("clock pin driven while slave");
  // main scenarios seen
  c_read: cover property ($fell(rd_n));
  c_quiet: cover property (quiet_q == 1);
  c_master: cover property (clk_sel && clk_io_oe);
endmodule

// >>> display_host_bus_port_tb_top.sv
// testbench: host and device ends joined, driven from the host request side
`timescale 1ns/1ps
module display_host_bus_port_tb_top;
  import disp_port_pkg::*;
  logic  clk, rst_n, req_valid, req_write, req_ready, rsp_valid; // host user side
  logic  disp_clk, blink_phase, clearing, master_clk, blink_sync_n, ext_clk;
  addr_t req_addr;        // request address
  data_t req_wdata;       // request write data
  data_t rsp_rdata;       // read answer
  data_t ctrl_word;       // device control word
  data_t digit0, digit1, digit2, digit3; // device characters
  data_t reg_m [8];       // register model by address
  data_t exp_q [$];       // expected read data, oldest first
  int    bad_count;       // mismatches
  int    n_checks;        // comparisons
  disp_port_if bus ();
  // external clock reaches the pin only while the device is not master
  assign bus.clk_io_in = bus.clk_io_oe ? bus.clk_io_out : ext_clk;
  disp_port_host disp_port_host_i (.clk(clk), .rst_n(rst_n), .bus(bus),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .master_clk(master_clk), .blink_sync_n(blink_sync_n));
  disp_port_device disp_port_device_i (.clk(clk), .rst_n(rst_n), .bus(bus),
    .ctrl_word(ctrl_word), .digit0(digit0), .digit1(digit1), .digit2(digit2),
    .digit3(digit3), .disp_clk(disp_clk), .blink_phase(blink_phase),
    .clearing(clearing));
  disp_port_asserts disp_port_asserts_i (.clk(clk), .rst_n(rst_n),
    .select_active_low(bus.select_active_low), .select_active_high(bus.select_active_high),
    .addr(bus.addr), .rd_n(bus.rd_n), .wr_n(bus.wr_n), .data_d_oe(bus.data_d_oe),
    .clk_sel(bus.clk_sel), .clk_io_oe(bus.clk_io_oe), .data_h_oe(bus.data_h_oe));
  // ----------------------------------
  // clock and shared tasks
  // ----------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input data_t seen, input data_t exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // one request; the model moves at the take, reads leave a note
  task automatic access(input logic wr, input addr_t a, input data_t d);
    int n;
    n = 0;
    // let the lowered request stand one cycle before the next one
    @(negedge clk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(data_t'(n < 200), 8'h01);
    if (n >= 200) results();
    @(negedge clk);
    req_valid = 1'b0;
    if (!wr) begin
      exp_q.push_back(reg_m[a]);
    end else if (a[ADDR_W-1]) begin
      reg_m[a] = d;
    end else begin
      for (n = 0; n < 8; n++) begin
        // clear blanks every character
        if (n < 4 || d[CLEAR_BIT]) reg_m[n] = n < 4 ? d : DIGIT_RESET;
      end
    end
  endtask
  // wait for answers, then the three-cycle commit
  task automatic settle;
    int n;
    n = 0;
    while ((exp_q.size() != 0 || req_ready !== 1'b1) && n < 300) begin
      @(negedge clk);
      n++;
    end
    check(data_t'(n < 300), 8'h01);
    if (n >= 300) results();
    repeat (4) @(negedge clk);
  endtask
  // back to back reads of every address, then the port values
  task automatic readall;
    for (int a = 0; a < 8; a++) access(1'b0, addr_t'(a), 8'h00);
    settle();
    check(ctrl_word, reg_m[0]);
    check(digit0, reg_m[4]);
    check(digit1, reg_m[5]);
    check(digit2, reg_m[6]);
    check(digit3, reg_m[7]);
  endtask
  // count operating clock changes over 40 cycles
  task automatic count_chg(input logic run, output int c);
    logic last;
    c = 0;
    last = disp_clk;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk);
      if (run && k % 5 == 0) ext_clk = ~ext_clk;
      if (disp_clk !== last) c++;
      last = disp_clk;
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------
  // monitor and watchdog
  // ----------------------------------
  // sampled mid-cycle, where the one-cycle answer has settled
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check(data_t'(exp_q.size()), 8'h01);
      else check(rsp_rdata, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
  // ----------------------------------
  // tests
  // ----------------------------------
  initial begin
    data_t v;
    int    c;
    {rst_n, req_valid, req_write, master_clk, ext_clk} = '0;
    blink_sync_n = 1'b1;
    req_addr = '0;
    req_wdata = '0;
    for (int i = 0; i < 8; i++) reg_m[i] = i < 4 ? CTRL_RESET : DIGIT_RESET;
    void'($urandom(1068));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    readall();
    $display("test reset values done");
    // random data at every address, clear bit kept low
    for (int i = 7; i >= 0; i--) begin
      v = data_t'($urandom);
      if (i < 4) v[CLEAR_BIT] = 1'b0;
      access(1'b1, addr_t'(i), v);
    end
    readall();
    $display("test write readback done");
    access(1'b1, 3'h2, 8'h80);
    settle();
    check(data_t'(clearing), 8'h01);
    readall();
    access(1'b1, 3'h1, 8'h13);
    settle();
    check(data_t'(clearing), 8'h00);
    access(1'b0, 3'h1, 8'h00);
    access(1'b1, 3'h6, 8'hC1);
    readall();
    $display("test clear done");
    blink_sync_n = 1'b0;
    repeat (8) @(negedge clk);
    blink_sync_n = 1'b1;
    readall();
    check(data_t'(blink_phase), 8'h00);
    $display("test blink sync done");
    master_clk = 1'b1;
    count_chg(1'b0, c);
    check(data_t'(bus.clk_io_oe), 8'h01);
    check(data_t'(c > 0), 8'h01);
    master_clk = 1'b0;
    count_chg(1'b1, c);
    count_chg(1'b1, c);
    check(data_t'(c > 0), 8'h01);
    count_chg(1'b0, c);
    count_chg(1'b0, c);
    check(data_t'(c), 8'h00);
    $display("test clock select done");
    results();
  end
endmodule
